// File: src/peam_pkg.sv
// package: constants, register map and carriers for the position error alarm monitor
package peam_pkg;
  localparam int unsigned ERR_W         = 32;
  localparam int unsigned THR_W         = 30;
  localparam int unsigned SPD_W         = 16;
  localparam int unsigned PCT_W         = 7;

  localparam logic [THR_W-1:0] THR_MAX          = 30'h3FFF_FFFF;
  localparam logic [THR_W-1:0] THR_MIN          = 30'h0000_0001;
  localparam logic [THR_W-1:0] RUN_THR_RST      = 30'h0050_0000;
  localparam logic [THR_W-1:0] SON_THR_RST      = 30'h0050_0000;
  localparam logic [PCT_W-1:0] SON_PCT_RST      = 7'h64;
  localparam logic [PCT_W-1:0] SON_PCT_MIN      = 7'h0A;
  localparam logic [PCT_W-1:0] SON_PCT_MAX      = 7'h64;
  localparam logic [SPD_W-1:0] SON_SPD_RST      = 16'h2710;

  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_RUN_THR   = 12'h004;
  localparam logic [11:0] OFS_SON_THR   = 12'h008;
  localparam logic [11:0] OFS_SON_PCT   = 12'h00C;
  localparam logic [11:0] OFS_SON_SPD   = 12'h010;
  localparam logic [11:0] OFS_STATUS    = 12'h014;
  localparam logic [11:0] OFS_ERROR     = 12'h018;

  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_CLR_BIT  = 4;

  typedef enum logic [1:0] {
    PEAM_MODE_SPEED  = 2'b00,
    PEAM_MODE_POS    = 2'b01,
    PEAM_MODE_TORQUE = 2'b10
  } peam_mode_t;

  typedef enum logic [1:0] {
    PEAM_ST_OFF    = 2'b00,
    PEAM_ST_RETURN = 2'b01,
    PEAM_ST_RUN    = 2'b10
  } peam_state_t;

  typedef struct packed {
    logic              ref_valid;
    logic signed [15:0] ref_delta;
    logic              fb_valid;
    logic signed [15:0] fb_delta;
  } peam_motion_t;

  typedef struct packed {
    logic run_alarm;
    logic son_overflow;
    logic spd_overflow;
  } peam_alarm_t;

  function automatic logic [ERR_W-1:0] peam_mag(input logic signed [ERR_W-1:0] v);
    peam_mag = v[ERR_W-1] ? ERR_W'(-v) : v;
  endfunction
endpackage

// File: src/peam_apb_regs.sv
// apb slave holding the monitor's thresholds, mode and status read-back
`timescale 1ns/1ps
module peam_apb_regs
  import peam_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     ce,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [31:0]              status_word,
  input  wire logic [31:0]              error_word,
  output logic      [1:0]               mode,
  output logic                          clear_alarms,
  output logic      [THR_W-1:0]         run_error_threshold,
  output logic      [THR_W-1:0]         servo_on_error_threshold,
  output logic      [PCT_W-1:0]         servo_on_error_percent,
  output logic      [SPD_W-1:0]         servo_on_speed_limit
);
  logic             acc;
  logic             hit;
  logic [31:0]      rd;
  logic [1:0]       next_mode;
  logic             next_clear;
  logic [THR_W-1:0] next_run;
  logic [THR_W-1:0] next_son;
  logic [PCT_W-1:0] next_pct;
  logic [SPD_W-1:0] next_spd;
  logic [31:0]      next_prdata;
  logic             next_pslverr;

  // clamp a threshold write into its legal range
  function automatic logic [THR_W-1:0] thr_clamp(input logic [31:0] v);
    if (v[31:THR_W] != '0) begin
      thr_clamp = THR_MAX;
    end else if (v[THR_W-1:0] < THR_MIN) begin
      thr_clamp = THR_MIN;
    end else begin
      thr_clamp = v[THR_W-1:0];
    end
  endfunction

  assign acc = psel & penable;
  assign pready = 1'b1;

  always_comb begin
    hit = 1'b1;
    rd  = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:    rd = {30'h0000_0000, mode};
      OFS_RUN_THR: rd = {2'b00, run_error_threshold};
      OFS_SON_THR: rd = {2'b00, servo_on_error_threshold};
      OFS_SON_PCT: rd = {25'h000_0000, servo_on_error_percent};
      OFS_SON_SPD: rd = {16'h0000, servo_on_speed_limit};
      OFS_STATUS:  rd = status_word;
      OFS_ERROR:   rd = error_word;
      default:     hit = 1'b0;
    endcase
  end

  always_comb begin
    next_mode    = mode;
    next_clear   = 1'b0;
    next_run     = run_error_threshold;
    next_son     = servo_on_error_threshold;
    next_pct     = servo_on_error_percent;
    next_spd     = servo_on_speed_limit;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (psel & ~penable) begin
      next_prdata  = pwrite ? 32'h0000_0000 : rd;
      next_pslverr = ~hit;
    end else if (acc) begin
      next_pslverr = pslverr;
    end
    if (acc & pwrite & hit) begin
      case (paddr)
        OFS_CTRL: begin
          next_mode  = pwdata[CTRL_MODE_LSB +: 2];
          next_clear = pwdata[CTRL_CLR_BIT];
        end
        OFS_RUN_THR: next_run = thr_clamp(pwdata);
        OFS_SON_THR: next_son = thr_clamp(pwdata);
        OFS_SON_PCT: begin
          if (pwdata[6:0] < SON_PCT_MIN || pwdata[31:7] != '0) begin
            next_pct = (pwdata[31:7] != '0) ? SON_PCT_MAX : SON_PCT_MIN;
          end else if (pwdata[6:0] > SON_PCT_MAX) begin
            next_pct = SON_PCT_MAX;
          end else begin
            next_pct = pwdata[6:0];
          end
        end
        OFS_SON_SPD: next_spd = pwdata[SPD_W-1:0];
        default:     next_clear = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode                     <= PEAM_MODE_POS;
      clear_alarms             <= 1'b0;
      run_error_threshold      <= RUN_THR_RST;
      servo_on_error_threshold <= SON_THR_RST;
      servo_on_error_percent   <= SON_PCT_RST;
      servo_on_speed_limit     <= SON_SPD_RST;
      prdata                   <= 32'h0000_0000;
      pslverr                  <= 1'b0;
    end else if (ce) begin
      mode                     <= next_mode;
      clear_alarms             <= next_clear;
      run_error_threshold      <= next_run;
      servo_on_error_threshold <= next_son;
      servo_on_error_percent   <= next_pct;
      servo_on_speed_limit     <= next_spd;
      prdata                   <= next_prdata;
      pslverr                  <= next_pslverr;
    end
  end
endmodule

// File: src/peam_sync.sv
// two flip-flop synchroniser for a level from another domain
`timescale 1ns/1ps
module peam_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else if (ce) begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule

// File: src/peam_top.sv
// position error alarm monitor: error counter, servo-on sequencing and alarms
// Contract
// - raise run alarm when error count exceeds run threshold
// - run threshold 1..1073741823, default 5242880, effective at once
// - error equals reference minus actual, kept as running pulse count
// - run error check active only in position control mode
// - at servo-on with pending error, drive back, then zero count
// - at servo-on, overflow alarm if pending error exceeds servo-on threshold
// - limit speed after servo-on; alarm if error passes run threshold (code: only while driving back, checked only in cycles with a reference pulse)
`timescale 1ns/1ps
module peam_top
  import peam_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 ce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 servo_on_cmd,
  input  wire peam_pkg::peam_motion_t motion,
  output logic                      speed_limit_active,
  output logic      [SPD_W-1:0]     speed_limit,
  output logic signed [15:0]        return_cmd,
  output logic                      return_valid,
  output peam_pkg::peam_alarm_t     alarms,
  output logic                      alarm_any
);
  import peam_pkg::*;

  logic [1:0]               mode;
  logic                     clear_alarms;
  logic [THR_W-1:0]         run_error_threshold;
  logic [THR_W-1:0]         servo_on_error_threshold;
  logic [PCT_W-1:0]         servo_on_error_percent;
  logic [SPD_W-1:0]         servo_on_speed_limit;
  logic                     son_sync;
  logic                     son_prev;
  logic                     son_rise;
  logic signed [ERR_W-1:0]  error_count;
  logic signed [ERR_W-1:0]  next_error;
  logic [ERR_W-1:0]         err_mag;
  peam_state_t              state;
  peam_state_t              next_state;
  peam_alarm_t              next_alarms;
  logic                     next_son_prev;
  logic                     next_limit_active;
  logic [SPD_W-1:0]         next_limit;
  logic signed [15:0]       next_ret;
  logic                     next_ret_valid;
  logic                     pos_mode;
  logic signed [15:0]       step;
  logic [31:0]              status_word;

  peam_apb_regs u_regs (
    .pclk                     (pclk),
    .presetn                  (presetn),
    .ce                       (ce),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .status_word              (status_word),
    .error_word               (error_count),
    .mode                     (mode),
    .clear_alarms             (clear_alarms),
    .run_error_threshold      (run_error_threshold),
    .servo_on_error_threshold (servo_on_error_threshold),
    .servo_on_error_percent   (servo_on_error_percent),
    .servo_on_speed_limit     (servo_on_speed_limit)
  );

  // servo-on arrives from the host's pin, so it is synchronised first
  peam_sync u_son (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       (servo_on_cmd),
    .q       (son_sync)
  );

  assign son_rise    = son_sync & ~son_prev;
  assign pos_mode    = (mode == PEAM_MODE_POS);
  assign err_mag     = peam_mag(error_count);
  assign status_word = {24'h00_0000, 1'b0, state, speed_limit_active, pos_mode,
                        alarms.spd_overflow, alarms.son_overflow, alarms.run_alarm};
  // the percentage register is stored for software only; the limit is latched unscaled

  // return step: bounded to +/-32767 so the drive-back always fits the 16-bit return command
  always_comb begin
    if (err_mag > ERR_W'(16'h7FFF)) begin
      step = error_count[ERR_W-1] ? 16'sh8001 : 16'sh7FFF;
    end else begin
      step = error_count[15:0];
    end
  end

  always_comb begin
    next_error        = error_count;
    next_state        = state;
    next_alarms       = alarms;
    next_son_prev     = son_sync;
    next_limit_active = speed_limit_active;
    next_limit        = speed_limit;
    next_ret          = 16'sh0000;
    next_ret_valid    = 1'b0;
    if (motion.ref_valid) begin
      next_error = next_error + ERR_W'(motion.ref_delta);
    end
    if (motion.fb_valid) begin
      next_error = next_error - ERR_W'(motion.fb_delta);
    end
    if (clear_alarms) begin
      next_alarms = '0;
    end
    case (state)
      PEAM_ST_OFF: begin
        next_limit_active = 1'b0;
        if (son_rise) begin
          if (err_mag > ERR_W'(servo_on_error_threshold)) begin
            next_alarms.son_overflow = 1'b1;
          end
          if (error_count != '0) begin
            next_state        = PEAM_ST_RETURN;
            next_limit_active = 1'b1;
            next_limit        = servo_on_speed_limit;
          end else begin
            next_state = PEAM_ST_RUN;
          end
        end
      end
      PEAM_ST_RETURN: begin
        if (!son_sync) begin
          next_state = PEAM_ST_OFF;
        end else if (error_count == '0) begin
          next_error        = '0;
          next_state        = PEAM_ST_RUN;
          next_limit_active = 1'b0;
        end else begin
          next_ret       = step;
          next_ret_valid = 1'b1;
          if (motion.ref_valid && err_mag > ERR_W'(run_error_threshold)) begin
            next_alarms.spd_overflow = 1'b1;
          end
        end
      end
      PEAM_ST_RUN: begin
        if (!son_sync) begin
          next_state = PEAM_ST_OFF;
        end
      end
      default: next_state = PEAM_ST_OFF;
    endcase
    // hardware set wins over a software clear in the same cycle
    if (pos_mode && err_mag > ERR_W'(run_error_threshold)) begin
      next_alarms.run_alarm = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_count        <= '0;
      state              <= PEAM_ST_OFF;
      alarms             <= '0;
      son_prev           <= 1'b0;
      speed_limit_active <= 1'b0;
      speed_limit        <= SON_SPD_RST;
      return_cmd         <= 16'sh0000;
      return_valid       <= 1'b0;
      alarm_any          <= 1'b0;
    end else if (ce) begin
      error_count        <= next_error;
      state              <= next_state;
      alarms             <= next_alarms;
      son_prev           <= next_son_prev;
      speed_limit_active <= next_limit_active;
      speed_limit        <= next_limit;
      return_cmd         <= next_ret;
      return_valid       <= next_ret_valid;
      alarm_any          <= |next_alarms;
    end
  end
endmodule

// File: sim/peam_properties.sv
// checker: port-level properties of the position error alarm monitor
`timescale 1ns/1ps
module peam_checker
  import peam_pkg::*;
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  ce,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  servo_on_cmd,
  input wire logic                  speed_limit_active,
  input wire logic [peam_pkg::SPD_W-1:0] speed_limit,
  input wire logic                  return_valid,
  input wire peam_pkg::peam_alarm_t alarms,
  input wire logic                  alarm_any
);
  import peam_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr;
  // the clear lands two edges after the write's access cycle, so that cycle and the next two are excluded
  assign clr = ce && psel && penable && pwrite && paddr == OFS_CTRL && pwdata[CTRL_CLR_BIT];
  sequence s_no_clr;
    !clr && !$past(clr) && !$past(clr, 2);
  endsequence
  sequence s_bad_addr;
    psel && penable && (paddr > OFS_ERROR || paddr[1:0] != 2'b00);
  endsequence
  sequence s_servo_off;
    !servo_on_cmd [*5];
  endsequence
  property p_ready; pready; endproperty
  property p_unmapped; s_bad_addr |-> pslverr; endproperty
  property p_run_sticky; alarms.run_alarm ##0 s_no_clr |=> alarms.run_alarm; endproperty
  property p_son_sticky; alarms.son_overflow ##0 s_no_clr |=> alarms.son_overflow; endproperty
  property p_spd_sticky; alarms.spd_overflow ##0 s_no_clr |=> alarms.spd_overflow; endproperty
  property p_any; (|alarms) |-> ##[0:1] alarm_any; endproperty
  property p_spd_cause; $rose(alarms.spd_overflow) |-> $past(speed_limit_active); endproperty
  property p_son_cause; $rose(alarms.son_overflow) |-> $past(servo_on_cmd); endproperty
  property p_ret_lim; return_valid |-> speed_limit_active || $past(speed_limit_active); endproperty
  property p_off; s_servo_off |=> !speed_limit_active && !return_valid; endproperty
  property p_lim_hold;
    speed_limit_active && $past(speed_limit_active) |-> $stable(speed_limit);
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_unmapped: assert property (p_unmapped) else $error("no slave error on unmapped address");
  a_run_sticky: assert property (p_run_sticky) else $error("run alarm dropped");
  a_son_sticky: assert property (p_son_sticky) else $error("servo-on alarm dropped");
  a_spd_sticky: assert property (p_spd_sticky) else $error("speed alarm dropped");
  a_any: assert property (p_any) else $error("summary alarm missing");
  a_spd_cause: assert property (p_spd_cause) else $error("speed alarm outside limit");
  a_son_cause: assert property (p_son_cause) else $error("servo-on alarm without servo-on");
  a_ret_lim: assert property (p_ret_lim) else $error("drive-back without limit");
  a_off: assert property (p_off) else $error("return active with servo off");
  a_lim_hold: assert property (p_lim_hold) else $error("speed limit moved");
endmodule
bind peam_top peam_checker u_peam_checker (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .pslverr(pslverr), .servo_on_cmd(servo_on_cmd),
  .speed_limit_active(speed_limit_active), .speed_limit(speed_limit),
  .return_valid(return_valid), .alarms(alarms), .alarm_any(alarm_any));

// File: sim/peam_host_model.sv
// host side model: motor feedback that follows the drive-back steps
`timescale 1ns/1ps
module peam_host_model (
  input  wire logic               stall,
  input  wire logic               return_valid,
  input  wire logic signed [15:0] return_cmd,
  input  wire logic               tb_fb_valid,
  input  wire logic signed [15:0] tb_fb_delta,
  output logic                    fb_valid,
  output logic signed [15:0]      fb_delta
);
  // a stalled motor ignores the drive-back, so the error stays pending
  assign fb_valid = tb_fb_valid || (return_valid && !stall);
  // idle data is inverted so a stale value is never mistaken for a step
  assign fb_delta = tb_fb_valid ? tb_fb_delta : (fb_valid ? return_cmd : ~return_cmd);
endmodule

// File: sim/peam_top_tb.sv
// self-checking bench for the position error alarm monitor
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module peam_top_tb;
  import peam_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, servo_on_cmd, stall, rv, fv, se, m_run;
  logic pready, pslverr, speed_limit_active, return_valid, alarm_any, fb_valid;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, rd;
  logic [31:0]        rst_exp [7];
  logic [SPD_W-1:0]   speed_limit;
  logic signed [15:0] return_cmd, rdl, fdl, fb_delta;
  peam_motion_t       motion;
  peam_alarm_t        alarms;
  int                 err_count, samples_checked, m_err, m_thr, n;
  assign motion = '{ref_valid: rv, ref_delta: rdl, fb_valid: fb_valid, fb_delta: fb_delta};
  peam_top u_peam_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .servo_on_cmd(servo_on_cmd), .motion(motion),
    .speed_limit_active(speed_limit_active), .speed_limit(speed_limit),
    .return_cmd(return_cmd), .return_valid(return_valid), .alarms(alarms),
    .alarm_any(alarm_any));
  peam_host_model u_host (.stall(stall), .return_valid(return_valid), .return_cmd(return_cmd),
    .tb_fb_valid(fv), .tb_fb_delta(fdl), .fb_valid(fb_valid), .fb_delta(fb_delta));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      err_count++;
      end_sim();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrc(input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    apb(1'b1, a, d);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("register", e, rd)
  endtask
  task automatic step(input int r, input int f);
    @(posedge pclk);
    rv <= r != 0;
    rdl <= 16'(r);
    fv <= f != 0;
    fdl <= 16'(f);
    @(posedge pclk);
    rv <= 1'b0;
    fv <= 1'b0;
    m_err += r - f;
  endtask
  // behavioural run check: sticky alarm on magnitude above threshold
  task automatic chk_run(input logic pos);
    repeat (3) @(posedge pclk);
    if (pos && (m_err < 0 ? -m_err : m_err) > m_thr) m_run = 1'b1;
    `CHK("run_alarm", m_run, alarms.run_alarm)
  endtask
  task automatic clear_pos;
    apb(1'b1, OFS_CTRL, 32'h0000_0011);
    m_run = 1'b0;
  endtask
  task automatic wait_lim(input logic v);
    n = 0;
    while (speed_limit_active !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    `CHK("limit_active", v, speed_limit_active)
    if (n >= 200) begin
      end_sim();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, servo_on_cmd, stall, rv, fv, m_run} = '0;
    ce = 1'b1;
    paddr = '0;
    pwdata = '0;
    rdl = '0;
    fdl = '0;
    {err_count, samples_checked, m_err} = '0;
    m_thr = 5242880;
    rst_exp = '{32'(PEAM_MODE_POS), 32'(RUN_THR_RST), 32'(SON_THR_RST), 32'(SON_PCT_RST),
      32'(SON_SPD_RST), 32'h0000_0008, 32'h0000_0000};
    void'($urandom(78));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("speed_limit", SON_SPD_RST, speed_limit)
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0000_0000);
      `CHK("reset value", rst_exp[i], rd)
    end
    apb(1'b0, 12'h01C, 32'h0000_0000);
    `CHK("slave error", 1'b1, se)
    `CHK("unmapped read", 32'h0000_0000, rd)
    wrc(OFS_RUN_THR, 32'h0000_0000, 32'h0000_0001);
    wrc(OFS_RUN_THR, 32'hFFFF_FFFF, 32'h3FFF_FFFF);
    wrc(OFS_SON_THR, 32'h0000_0000, 32'h0000_0001);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      step(int'($urandom_range(200)) - 100, int'($urandom_range(200)) - 100);
    end
    step(1000, 0);
    apb(1'b0, OFS_ERROR, 32'h0000_0000);
    `CHK("error count", 32'(m_err), rd)
    // leave position mode first, so the tiny threshold cannot trip the alarm early
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    m_thr = 1;
    wrc(OFS_RUN_THR, 32'h0000_0001, 32'h0000_0001);
    for (int md = 0; md < 3; md += 2) begin
      apb(1'b1, OFS_CTRL, 32'(md));
      chk_run(1'b0);
    end
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    chk_run(1'b1);
    m_thr = m_err;
    apb(1'b1, OFS_RUN_THR, 32'(m_thr));
    clear_pos();
    chk_run(1'b1);
    step(1, 0);
    chk_run(1'b1);
    m_thr = m_err;
    apb(1'b1, OFS_RUN_THR, 32'(m_thr));
    clear_pos();
    step(-2 * m_err, 0);
    chk_run(1'b1);
    step(0, 1);
    chk_run(1'b1);
    apb(1'b0, OFS_ERROR, 32'h0000_0000);
    `CHK("error count", 32'(m_err), rd)
    $display("test run check done");
    apb(1'b1, OFS_RUN_THR, 32'h0000_0BB8);
    apb(1'b1, OFS_SON_THR, 32'h0000_000A);
    apb(1'b1, OFS_SON_SPD, 32'h0000_1234);
    clear_pos();
    @(posedge pclk);
    stall <= 1'b1;
    servo_on_cmd <= 1'b1;
    wait_lim(1'b1);
    `CHK("speed_limit", 16'h1234, speed_limit)
    @(posedge pclk);
    `CHK("son_overflow", (m_err < 0 ? -m_err : m_err) > 10, alarms.son_overflow)
    step(8000, 0);
    step(1, 0);
    repeat (2) @(posedge pclk);
    `CHK("spd_overflow", 1'b1, alarms.spd_overflow)
    `CHK("alarm_any", 1'b1, alarm_any)
    `CHK("return_valid", 1'b1, return_valid)
    `CHK("return_cmd", 16'(m_err), return_cmd)
    stall <= 1'b0;
    wait_lim(1'b0);
    apb(1'b0, OFS_ERROR, 32'h0000_0000);
    `CHK("error count", 32'h0000_0000, rd)
    servo_on_cmd <= 1'b0;
    repeat (6) @(posedge pclk);
    `CHK("limit_active", 1'b0, speed_limit_active)
    $display("test servo-on done");
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    end_sim();
  end
endmodule
